// file: verilog/supervisor_params.svh
// Timing and reset constants for the supervisor block
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

// Timebase
`define CLK_FREQ_HZ            40000000
`define CLK_PERIOD_NS          25
// Reset hold period, nominal 200 ms (window 140 to 280 ms)
`define RESET_HOLD_MS          200
`define RESET_HOLD_CYCLES      ((`RESET_HOLD_MS * (`CLK_FREQ_HZ / 1000)))
// Watchdog timeout, nominal 1.6 s (window 1.0 to 2.25 s), kept in ms
`define WDOG_TIMEOUT_MS        1600
`define WDOG_TIMEOUT_CYCLES    ((`WDOG_TIMEOUT_MS * (`CLK_FREQ_HZ / 1000)))
// Manual reset must be stable this long before it counts (150 ns min pulse)
`define MR_MIN_PULSE_NS        150
`define MR_DEBOUNCE_CYCLES     ((`MR_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Counter widths
`define HOLD_CNT_W             24
`define WDOG_CNT_W             27
`define DEB_CNT_W              4
// Synchroniser reset value
`define SYNC_RST_VAL           1'b1

`endif

// file: verilog/supervisor_pkg.sv
// Types shared by the supervisor block
package supervisor_pkg;

  // Reset sequencer states, one-hot
  typedef enum logic [2:0]
  {
    RST_ACTIVE = 3'b001,
    RST_HOLD   = 3'b010,
    RST_RUN    = 3'b100
  } rst_state_e;

endpackage

// file: verilog/sync_2ff.sv
// Two flip-flop synchroniser for one level input
`timescale 1ns/1ps
`include "supervisor_params.svh"

module sync_2ff
(
  // Clock and control
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  // Data
  input  wire logic din,
  output logic      dout
);

  logic stage1;
  logic next_stage1;
  logic next_dout;

  // First stage feeds only the second stage
  always_comb
  begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  // Register both stages; reset to inactive-high level
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      stage1 <= `SYNC_RST_VAL;
      dout   <= `SYNC_RST_VAL;
    end
    else if (clk_en)
    begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end

endmodule

// file: verilog/debounce.sv
// Stability filter: output follows input once it holds steady
`timescale 1ns/1ps
`include "supervisor_params.svh"

module debounce
(
  // Clock and control
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  // Data
  input  wire logic din,
  output logic      dout
);

  logic [`DEB_CNT_W-1:0] cnt;
  logic [`DEB_CNT_W-1:0] next_cnt;
  logic                  next_dout;

  // Count cycles that input differs from output; short glitches are dropped
  always_comb
  begin
    next_cnt  = '0;
    next_dout = dout;
    if (din != dout)
    begin
      if (cnt >= `DEB_CNT_W'(`MR_DEBOUNCE_CYCLES - 1))
        next_dout = din;
      else
        next_cnt = cnt + `DEB_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cnt  <= '0;
      dout <= 1'b1;
    end
    else if (clk_en)
    begin
      cnt  <= next_cnt;
      dout <= next_dout;
    end
  end

endmodule

// file: verilog/supervisor_reset_watchdog.sv
// Supervisor: reset stretcher, watchdog timer and power-fail warning
// Notes on behaviour
// - Reset asserted while supply is low.
// - Reset asserted while manual reset held low.
// - Reset held 200 ms after cause clears.
// - Reset hold lies within 140-280 ms.
// - Any kick edge restarts watchdog count.
// - Kick idle past timeout drives expiry low.
// - Watchdog timeout lies within 1.0-2.25 s.
// - Any single kick level change is valid.
// - Disable input suppresses watchdog expiry unless supply is low.
// - Expiry alone never asserts reset outputs.
// - Expiry routed to manual reset holds 200 ms.
// - Expiry output low while supply is low.
// - Watchdog stops counting while supply low.
// - Active-high reset is inverse of low.
// - Warning high when sense above reference.
// - Warning path independent of other logic.
// - Backup switchover forces warning low.
`timescale 1ns/1ps
`include "supervisor_params.svh"

module supervisor_reset_watchdog
#(
  parameter int unsigned RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES,
  parameter int unsigned WDOG_CYCLES       = `WDOG_TIMEOUT_CYCLES
)
(
  // Clock, reset, enable
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  // Comparator results and strap inputs
  input  wire logic supply_low,
  input  wire logic backup_switchover,
  input  wire logic power_fail_sense_in,
  // Host side inputs
  input  wire logic manual_reset_req_n,
  input  wire logic watchdog_kick_in,
  input  wire logic watchdog_disable,
  // Outputs
  output logic      reset_out_n,
  output logic      reset_out,
  output logic      watchdog_expired_n,
  output logic      power_fail_warn_n
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------

  logic supply_low_s;
  logic supply_ok_s;
  logic mr_s;
  logic mr_n;
  logic kick_s;
  logic pf_sense_s;
  logic switchover_s;
  logic no_switch_s;

  // Active-high pins pass inverted: the flops reset high, which must read as idle,
  // else a false supply-low and a warning pulse would follow every reset
  assign supply_low_s = ~supply_ok_s;
  assign switchover_s = ~no_switch_s;

  // Five asynchronous pins, each through two flops
  sync_2ff u_sync_supply (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
                          .din(~supply_low), .dout(supply_ok_s));
  sync_2ff u_sync_mr     (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
                          .din(manual_reset_req_n), .dout(mr_s));
  sync_2ff u_sync_kick   (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
                          .din(watchdog_kick_in), .dout(kick_s));
  sync_2ff u_sync_pf     (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
                          .din(power_fail_sense_in), .dout(pf_sense_s));
  sync_2ff u_sync_sw     (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
                          .din(~backup_switchover), .dout(no_switch_s));

  // Pulses shorter than the minimum width are not seen as requests
  debounce u_deb_mr (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
                     .din(mr_s), .dout(mr_n));

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------

  supervisor_pkg::rst_state_e   state;
  supervisor_pkg::rst_state_e   next_state;
  logic [`HOLD_CNT_W-1:0]       hold_cnt;
  logic [`HOLD_CNT_W-1:0]       next_hold_cnt;
  logic                         reset_cause;
  logic                         next_reset_out_n;

  // Watchdog expiry is not a cause; it must be wired back to manual reset
  assign reset_cause = supply_low_s | ~mr_n;

  // Hold reset for the full period after every cause clears
  always_comb
  begin
    next_state       = state;
    next_hold_cnt    = hold_cnt;
    next_reset_out_n = 1'b0;
    unique case (state)
      supervisor_pkg::RST_ACTIVE:
      begin
        next_hold_cnt = '0;
        if (!reset_cause)
          next_state = supervisor_pkg::RST_HOLD;
      end
      supervisor_pkg::RST_HOLD:
      begin
        if (reset_cause)
        begin
          next_state    = supervisor_pkg::RST_ACTIVE;
          next_hold_cnt = '0;
        end
        else if (hold_cnt >= `HOLD_CNT_W'(RESET_HOLD_CYCLES - 1))
        begin
          next_state       = supervisor_pkg::RST_RUN;
          next_reset_out_n = 1'b1;
        end
        else
          next_hold_cnt = hold_cnt + `HOLD_CNT_W'(1);
      end
      supervisor_pkg::RST_RUN:
      begin
        next_reset_out_n = 1'b1;
        if (reset_cause)
        begin
          next_state       = supervisor_pkg::RST_ACTIVE;
          next_reset_out_n = 1'b0;
        end
      end
      default:
      begin
        next_state    = supervisor_pkg::RST_ACTIVE;
        next_hold_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state       <= supervisor_pkg::RST_ACTIVE;
      hold_cnt    <= '0;
      reset_out_n <= 1'b0;
    end
    else if (clk_en)
    begin
      state       <= next_state;
      hold_cnt    <= next_hold_cnt;
      reset_out_n <= next_reset_out_n;
    end
  end

  // Complement output, kept combinational so the two never disagree
  assign reset_out = ~reset_out_n;

  // ----------------------------------------------------------------
  // Watchdog timer
  // ----------------------------------------------------------------

  logic [`WDOG_CNT_W-1:0] wd_cnt;
  logic [`WDOG_CNT_W-1:0] next_wd_cnt;
  logic                   kick_prev;
  logic                   kick_edge;
  logic                   next_expired_n;

  // Either edge counts, so a single level change is enough
  assign kick_edge = kick_s ^ kick_prev;

  // Count cleared and expiry forced low while supply is low; otherwise disable keeps output high
  always_comb
  begin
    next_wd_cnt    = wd_cnt;
    next_expired_n = watchdog_expired_n;
    if (supply_low_s)
    begin
      next_wd_cnt    = '0;
      next_expired_n = 1'b0;
    end
    else if (watchdog_disable)
    begin
      next_wd_cnt    = '0;
      next_expired_n = 1'b1;
    end
    else if (kick_edge)
    begin
      next_wd_cnt    = '0;
      next_expired_n = 1'b1;
    end
    else if (wd_cnt >= `WDOG_CNT_W'(WDOG_CYCLES - 1))
      next_expired_n = 1'b0;
    else
    begin
      next_wd_cnt    = wd_cnt + `WDOG_CNT_W'(1);
      next_expired_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      wd_cnt             <= '0;
      kick_prev          <= 1'b1;
      watchdog_expired_n <= 1'b1;
    end
    else if (clk_en)
    begin
      wd_cnt             <= next_wd_cnt;
      kick_prev          <= kick_s;
      watchdog_expired_n <= next_expired_n;
    end
  end

  // ----------------------------------------------------------------
  // Power-fail warning
  // ----------------------------------------------------------------

  logic next_pf_warn_n;

  // Shares nothing with reset or watchdog; switchover wins to save power
  always_comb
  begin
    next_pf_warn_n = pf_sense_s & ~switchover_s;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      power_fail_warn_n <= 1'b1;
    else if (clk_en)
      power_fail_warn_n <= next_pf_warn_n;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  a_supply_holds_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && supply_low_s |=> !reset_out_n)
    else $error("reset released while supply low");

  a_mr_holds_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && !mr_n |=> !reset_out_n)
    else $error("reset released while manual reset low");

  a_release_after_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(reset_out_n) |-> $past(hold_cnt) == `HOLD_CNT_W'(RESET_HOLD_CYCLES - 1))
    else $error("reset released before hold period");

  a_reset_complement: assert property (@(posedge ref_clk) disable iff (!rstn)
    reset_out == !reset_out_n)
    else $error("reset outputs disagree");

  a_kick_clears_count: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && kick_edge && !supply_low_s |=> wd_cnt == '0 && watchdog_expired_n)
    else $error("kick did not restart watchdog");

  a_expiry_on_timeout: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && !supply_low_s && !watchdog_disable && !kick_edge
      && wd_cnt == `WDOG_CNT_W'(WDOG_CYCLES - 1) |=> !watchdog_expired_n)
    else $error("watchdog did not expire at timeout");

  a_expiry_low_supply: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && supply_low_s |=> !watchdog_expired_n && wd_cnt == '0)
    else $error("expiry not forced while supply low");

  a_disable_no_expiry: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && watchdog_disable && !supply_low_s |=> watchdog_expired_n)
    else $error("expiry while watchdog disabled");

  a_pf_warn_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en |=> power_fail_warn_n == ($past(pf_sense_s) && !$past(switchover_s)))
    else $error("power-fail warning wrong");

  a_expiry_no_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && mr_n && !supply_low_s && state == supervisor_pkg::RST_RUN |=> reset_out_n)
    else $error("reset asserted without a cause");

  a_hold_keeps_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    state == supervisor_pkg::RST_HOLD |-> !reset_out_n)
    else $error("reset released during hold");

  a_hold_entry: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && state == supervisor_pkg::RST_ACTIVE && !reset_cause
      |=> state == supervisor_pkg::RST_HOLD && hold_cnt == '0)
    else $error("hold did not start from zero");

  a_hold_bounded: assert property (@(posedge ref_clk) disable iff (!rstn)
    hold_cnt <= `HOLD_CNT_W'(RESET_HOLD_CYCLES - 1))
    else $error("hold count past its limit");

  a_wdog_bounded: assert property (@(posedge ref_clk) disable iff (!rstn)
    wd_cnt <= `WDOG_CNT_W'(WDOG_CYCLES - 1))
    else $error("watchdog count past its limit");

  a_disable_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && watchdog_disable |=> wd_cnt == '0)
    else $error("watchdog counted while disabled");

  a_switchover_warn: assert property (@(posedge ref_clk) disable iff (!rstn)
    clk_en && switchover_s |=> !power_fail_warn_n)
    else $error("warning high during switchover");

  a_enable_freeze: assert property (@(posedge ref_clk) disable iff (!rstn)
    !clk_en |=> $stable(state) && $stable(hold_cnt) && $stable(wd_cnt) && $stable(reset_out_n))
    else $error("state moved with enable low");

endmodule

// file: test/host_model.sv
// Host processor model: kicks the watchdog and drives manual reset
`timescale 1ns/1ps

module host_model
#(
  parameter int KICK_GAP = 20
)
(
  // Controls from the bench
  input  wire logic ref_clk,
  input  wire logic kick_en,
  input  wire logic route_expiry,
  input  wire logic mr_drive_n,
  // Device pins
  input  wire logic watchdog_expired_n,
  output logic      watchdog_kick_in,
  output logic      manual_reset_req_n
);
  int   gap = 0;
  logic kick_lvl = 1'b0;
  logic kick_en_q = 1'b0;

  assign watchdog_kick_in = kick_lvl;

  // Enable taken at the rising edge, so a bench change at the falling edge never races
  always @(posedge ref_clk)
    kick_en_q <= kick_en;

  // Toggle the kick every KICK_GAP cycles; one level change is a whole kick
  always @(negedge ref_clk)
  begin
    gap = kick_en_q ? gap + 1 : KICK_GAP - 1;
    if (gap >= KICK_GAP)
    begin
      gap = 0;
      kick_lvl = ~kick_lvl;
    end
  end

  // Expiry reaches reset only through this optional wire to manual reset
  assign manual_reset_req_n = mr_drive_n & (watchdog_expired_n | ~route_expiry);
endmodule

// file: test/supervisor_reset_watchdog_test.sv
// Self-checking bench for the supervisor block
`timescale 1ns/1ps

module supervisor_reset_watchdog_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk;
  logic rstn;
  logic clk_en;
  logic supply_low;
  logic backup_switchover;
  logic power_fail_sense_in;
  logic watchdog_disable;
  logic kick_en;
  logic route_expiry;
  logic mr_drive_n;
  logic s;
  logic w;
  wire  manual_reset_req_n;
  wire  watchdog_kick_in;
  wire  reset_out_n;
  wire  reset_out;
  wire  watchdog_expired_n;
  wire  power_fail_warn_n;
  int   errors = 0;
  int   comparisons = 0;
  int   cycles = 0;
  int   n;
  int   i;

  // Short counts keep the run brief; hold 20, watchdog 50 cycles
  supervisor_reset_watchdog #(.RESET_HOLD_CYCLES(20), .WDOG_CYCLES(50))
    supervisor_reset_watchdog_inst
  (
    .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .supply_low(supply_low),
    .backup_switchover(backup_switchover), .power_fail_sense_in(power_fail_sense_in),
    .manual_reset_req_n(manual_reset_req_n), .watchdog_kick_in(watchdog_kick_in),
    .watchdog_disable(watchdog_disable), .reset_out_n(reset_out_n),
    .reset_out(reset_out), .watchdog_expired_n(watchdog_expired_n),
    .power_fail_warn_n(power_fail_warn_n)
  );

  host_model host_model_inst
  (
    .ref_clk(ref_clk), .kick_en(kick_en), .route_expiry(route_expiry),
    .mr_drive_n(mr_drive_n), .watchdog_expired_n(watchdog_expired_n),
    .watchdog_kick_in(watchdog_kick_in), .manual_reset_req_n(manual_reset_req_n)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always #12.5 ref_clk = ~ref_clk;

  // Ceiling well above the thousand or so cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles > 30000)
    begin
      errors++;
      give_verdict();
    end
  end

  function automatic logic exp_warn(input logic sense, input logic sw);
    return sense & ~sw;
  endfunction

  task automatic check(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask

  // Outputs are settled at the falling edge, where inputs also change
  task automatic tick(input int cnt);
    repeat (cnt)
    begin
      @(negedge ref_clk);
      check(reset_out, ~reset_out_n);
    end
  endtask

  // Bounded wait on reset (sel 0) or expiry (sel 1)
  task automatic wait_lvl(input bit sel, input logic val, input int max);
    n = 0;
    while (((sel ? watchdog_expired_n : reset_out_n) !== val) && n < max)
    begin
      tick(1);
      n++;
    end
  endtask

  task automatic give_verdict;
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    supply_low = 1'b0;
    backup_switchover = 1'b0;
    power_fail_sense_in = 1'b1;
    watchdog_disable = 1'b0;
    kick_en = 1'b1;
    route_expiry = 1'b0;
    mr_drive_n = 1'b1;
    i = $urandom(52677);
    tick(20);
    check(reset_out_n, 1'b0);
    check(power_fail_warn_n, 1'b1);
    rstn = 1'b1;
    tick(10);
    check(reset_out_n, 1'b0);
    wait_lvl(0, 1'b1, 40);
    check(reset_out_n, 1'b1);
    // Hold of 20 cycles scaled by the 140/200 and 280/200 limits
    check((10 + n) inside {[14:28]}, 1'b1);
    // Warning path with random sense and switchover against periodic supply and manual reset activity
    for (i = 0; i < 24; i++)
    begin
      s = (i < 4) ? i[0] : 1'($urandom);
      w = (i < 4) ? i[1] : 1'($urandom);
      power_fail_sense_in = s;
      backup_switchover = w;
      supply_low = (i % 8 == 5);
      mr_drive_n = (i % 8 != 6);
      tick(5);
      check(power_fail_warn_n, exp_warn(s, w));
    end
    supply_low = 1'b0;
    mr_drive_n = 1'b1;
    wait_lvl(0, 1'b1, 60);
    // Regular kicks, then silence until expiry
    tick(200);
    check(watchdog_expired_n, 1'b1);
    kick_en = 1'b0;
    tick(25);
    check(watchdog_expired_n, 1'b1);
    wait_lvl(1, 1'b0, 40);
    check(watchdog_expired_n, 1'b0);
    tick(20);
    check(reset_out_n, 1'b1);
    kick_en = 1'b1;
    wait_lvl(1, 1'b1, 10);
    check(watchdog_expired_n, 1'b1);
    kick_en = 1'b0;
    // Enable low freezes the count: no expiry however long the kick is silent
    clk_en = 1'b0;
    tick(120);
    check(watchdog_expired_n, 1'b1);
    check(reset_out_n, 1'b1);
    clk_en = 1'b1;
    watchdog_disable = 1'b1;
    tick(150);
    check(watchdog_expired_n, 1'b1);
    watchdog_disable = 1'b0;
    kick_en = 1'b1;
    tick(5);
    // Expiry wired into manual reset
    route_expiry = 1'b1;
    kick_en = 1'b0;
    wait_lvl(1, 1'b0, 80);
    wait_lvl(0, 1'b0, 15);
    check(reset_out_n, 1'b0);
    kick_en = 1'b1;
    wait_lvl(1, 1'b1, 10);
    tick(12);
    check(reset_out_n, 1'b0);
    wait_lvl(0, 1'b1, 40);
    check(reset_out_n, 1'b1);
    route_expiry = 1'b0;
    // Supply low with no kicks: expiry forced low, count held at zero
    kick_en = 1'b0;
    supply_low = 1'b1;
    tick(5);
    check(reset_out_n, 1'b0);
    check(watchdog_expired_n, 1'b0);
    tick(100);
    check(watchdog_expired_n, 1'b0);
    supply_low = 1'b0;
    wait_lvl(1, 1'b1, 8);
    check(watchdog_expired_n, 1'b1);
    tick(10);
    check(reset_out_n, 1'b0);
    tick(25);
    check(watchdog_expired_n, 1'b1);
    wait_lvl(0, 1'b1, 40);
    check(reset_out_n, 1'b1);
    kick_en = 1'b1;
    // Manual reset: short glitch ignored, long press honoured
    mr_drive_n = 1'b0;
    tick(1 + $urandom_range(3));
    mr_drive_n = 1'b1;
    tick(20);
    check(reset_out_n, 1'b1);
    mr_drive_n = 1'b0;
    tick(10 + $urandom_range(20));
    check(reset_out_n, 1'b0);
    mr_drive_n = 1'b1;
    tick(12);
    check(reset_out_n, 1'b0);
    wait_lvl(0, 1'b1, 40);
    check(reset_out_n, 1'b1);
    give_verdict();
  end
endmodule
